//--- design/sdpram_pkg.sv
// Shared constants and types for the small embedded memory block and the
// fabric logic that drives it. Assumes one 50 MHz clock for both ends.
package sdpram_pkg;
    // Clock period in ns (50 MHz)
    localparam int CLK_PERIOD_NS = 20;
    localparam int TOTAL_BITS = 576;
    localparam int ROWS = 32;
    localparam int ROW_W = 18;
    localparam int ROW_IDX_W = 5;
    localparam int DATA_W = 16;
    localparam int COL_W = 4;
    localparam int BYTE_W = 8;
    localparam int LANE_W = 9;
    localparam int ADDR_W = 9;
    localparam int PORT_W = 18;
    localparam int TAPW_W = 5;
    localparam int LEN_W = 10;
    // Bit of the address that selects the byte lane in the 9-bit shape
    localparam int LANE_SEL_BIT = 0;
    // Highest address bit used by the 9-bit shape
    localparam int X9_ADDR_HI = 5;
    // Value shown for a read that collides with a write in don't-care mode
    localparam logic [PORT_W-1:0] UNKNOWN_FILL = 18'h3FFFF;
    localparam logic CLK_SEL_A = 1'b0;
    localparam logic CLK_SEL_B = 1'b1;

    typedef enum logic [2:0] {
        SHAPE_X1 = 3'h0,
        SHAPE_X2 = 3'h1,
        SHAPE_X4 = 3'h2,
        SHAPE_X8 = 3'h3,
        SHAPE_X16 = 3'h4,
        SHAPE_X9 = 3'h5,
        SHAPE_X18 = 3'h6
    } shape_type;

    typedef enum logic [2:0] {
        MODE_SDP = 3'h0,
        MODE_SINGLE = 3'h1,
        MODE_FIFO = 3'h2,
        MODE_ROM = 3'h3,
        MODE_SHIFT = 3'h4
    } mode_type;
endpackage

//--- design/sdpram_link_if.sv
// Carrier between the fabric logic and the memory block.
// Both ends sit on the same clock; the testbench instantiates it.
`timescale 1ns/1ps
interface sdpram_link_if;
    import sdpram_pkg::*;
    logic tick_a;
    logic tick_b;
    logic wr_clk_sel;
    logic rd_addr_clk_sel;
    logic rden_clk_sel;
    logic out_clk_sel;
    logic in_clk_en;
    logic out_clk_en;
    logic in_clr;
    logic out_clr;
    logic out_bypass;
    logic rdw_old;
    mode_type mode;
    shape_type wr_shape;
    shape_type rd_shape;
    logic [TAPW_W-1:0] tap_width;
    logic [LEN_W-1:0] tap_len;
    logic wren;
    logic [ADDR_W-1:0] waddr;
    logic [PORT_W-1:0] wdata;
    logic rden;
    logic [ADDR_W-1:0] raddr;
    logic [PORT_W-1:0] q;
    logic q_valid;

    modport device (
        input tick_a, tick_b, wr_clk_sel, rd_addr_clk_sel, rden_clk_sel,
        input out_clk_sel, in_clk_en, out_clk_en, in_clr, out_clr,
        input out_bypass, rdw_old, mode, wr_shape, rd_shape, tap_width,
        input tap_len, wren, waddr, wdata, rden, raddr,
        output q, q_valid
    );
    modport fabric (
        output tick_a, tick_b, wr_clk_sel, rd_addr_clk_sel, rden_clk_sel,
        output out_clk_sel, in_clk_en, out_clk_en, in_clr, out_clr,
        output out_bypass, rdw_old, mode, wr_shape, rd_shape, tap_width,
        output tap_len, wren, waddr, wdata, rden, raddr,
        input q, q_valid
    );
endinterface

//--- design/sdpram_cells.sv
// Storage array: 32 rows of 18 bits (two bytes, each with a parity bit).
// Assumes the caller builds the row mask; read is combinational.
`timescale 1ns/1ps
module sdpram_cells import sdpram_pkg::*; #(
    parameter logic [TOTAL_BITS-1:0] INIT_IMAGE = '0
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wr_en_in,
    input wire logic [ROW_IDX_W-1:0] wr_row_in,
    input wire logic [ROW_W-1:0] wr_mask_in,
    input wire logic [ROW_W-1:0] wr_bits_in,
    input wire logic [ROW_IDX_W-1:0] rd_row_in,
    output logic [ROW_W-1:0] rd_word_out
);
    logic [ROW_W-1:0] cell_r [ROWS];

    // One row of cells per entry, preloaded from the image at reset
    for (genvar g = 0; g < ROWS; g++) begin : g_row
        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                cell_r[g] <= INIT_IMAGE[g*ROW_W +: ROW_W];
            end else if (wr_en_in && wr_row_in == ROW_IDX_W'(g)) begin
                cell_r[g] <= (cell_r[g] & ~wr_mask_in) |
                             (wr_bits_in & wr_mask_in);
            end
        end
    end

    assign rd_word_out = cell_r[rd_row_in];
endmodule

//--- design/sdpram_block.sv
// Small embedded memory block: 576 bits, simple dual-port, single-port,
// FIFO, ROM and tapped shift register. Assumes fabric logic on the same
// clock drives every control through the link, already registered.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module sdpram_block import sdpram_pkg::*; #(
    parameter logic [TOTAL_BITS-1:0] INIT_IMAGE = '0
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    sdpram_link_if.device link,
    output logic shape_err_out
);
    logic tick_in, tick_raddr, tick_rden, tick_out;
    logic shape_bad, is_shift, is_fifo, write_ok;
    logic [ADDR_W-1:0] wr_addr_r, rd_addr_r, wr_ptr_r, rd_ptr_r;
    logic [ADDR_W-1:0] eff_waddr, eff_raddr;
    logic [LEN_W-1:0] sh_ptr_r;
    logic [PORT_W-1:0] wr_data_r, eff_wdata, rd_data, shifted, q_r;
    logic wr_strobe_r, rden_r, q_valid_r, shape_err_r;
    logic [ADDR_W-1:0] w_lin, r_lin;
    logic [ROW_W-1:0] wmask, wbits, row_word;
    shape_type rd_view;

    // Data width of a shape
    function automatic logic [TAPW_W-1:0] width_of(shape_type s);
        case (s)
            SHAPE_X1: width_of = 5'h01;
            SHAPE_X2: width_of = 5'h02;
            SHAPE_X4: width_of = 5'h04;
            SHAPE_X8: width_of = 5'h08;
            SHAPE_X16: width_of = 5'h10;
            SHAPE_X9: width_of = 5'h09;
            SHAPE_X18: width_of = 5'h12;
            default: width_of = 5'h01;
        endcase
    endfunction

    // Word count minus one, used to wrap FIFO pointers
    function automatic logic [ADDR_W-1:0] depth_mask(shape_type s);
        case (s)
            SHAPE_X1: depth_mask = 9'h1FF;
            SHAPE_X2: depth_mask = 9'h0FF;
            SHAPE_X4: depth_mask = 9'h07F;
            SHAPE_X8, SHAPE_X9: depth_mask = 9'h03F;
            default: depth_mask = 9'h01F;
        endcase
    endfunction

    function automatic logic is_parity(shape_type s);
        is_parity = (s == SHAPE_X9) || (s == SHAPE_X18);
    endfunction

    // Linear position: row in the upper bits, bit or lane offset below
    function automatic logic [ADDR_W-1:0] lin_of(logic [ADDR_W-1:0] a,
                                                 shape_type s);
        case (s)
            SHAPE_X1: lin_of = a;
            SHAPE_X2: lin_of = {a[ADDR_W-2:0], 1'b0};
            SHAPE_X4: lin_of = {a[ADDR_W-3:0], 2'h0};
            SHAPE_X8: lin_of = {a[ADDR_W-4:0], 3'h0};
            SHAPE_X16: lin_of = {a[ROW_IDX_W-1:0], 4'h0};
            SHAPE_X9: lin_of = {a[X9_ADDR_HI:1], 3'h0, a[LANE_SEL_BIT]};
            default: lin_of = {a[ROW_IDX_W-1:0], 4'h0};
        endcase
    endfunction

    // Row position of data bit d, skipping the parity bit after each byte
    function automatic int bit_pos(int d);
        bit_pos = d + d / BYTE_W;
    endfunction

    // Each register group picks its own clock tick
    assign tick_in = (link.wr_clk_sel == CLK_SEL_B ? link.tick_b
                      : link.tick_a) & link.in_clk_en;
    assign tick_raddr = (link.rd_addr_clk_sel == CLK_SEL_B ? link.tick_b
                         : link.tick_a) & link.out_clk_en;
    assign tick_rden = (link.rden_clk_sel == CLK_SEL_B ? link.tick_b
                        : link.tick_a) & link.out_clk_en;
    assign tick_out = (link.out_clk_sel == CLK_SEL_B ? link.tick_b
                       : link.tick_a) & link.out_clk_en;

    // Parity shapes only pair with themselves; other widths mix freely
    assign shape_bad = (is_parity(link.wr_shape) ||
                        is_parity(link.rd_shape)) &&
                       (link.wr_shape != link.rd_shape);
    assign is_shift = (link.mode == MODE_SHIFT);
    assign is_fifo = (link.mode == MODE_FIFO);
    // A single write port and a single read port: no true dual-port use
    assign write_ok = (link.mode != MODE_ROM) && !shape_bad;

    // Write-side input registers and the self-timed write strobe
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_addr_r <= '0;
            wr_data_r <= '0;
            wr_strobe_r <= 1'b0;
        end else if (link.in_clr) begin
            wr_addr_r <= '0;
            wr_data_r <= '0;
            wr_strobe_r <= 1'b0;
        end else begin
            wr_strobe_r <= tick_in & link.wren & write_ok;
            if (tick_in) begin
                wr_addr_r <= link.waddr;
                wr_data_r <= link.wdata;
            end
        end
    end

    // Read address and read enable registers, never bypassed
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_addr_r <= '0;
            rden_r <= 1'b0;
        end else if (link.out_clr) begin
            rd_addr_r <= '0;
            rden_r <= 1'b0;
        end else begin
            if (tick_raddr) begin
                if (link.mode == MODE_SINGLE) begin
                    rd_addr_r <= link.waddr; // Shared address
                end else if (is_fifo) begin
                    rd_addr_r <= rd_ptr_r;
                end else begin
                    rd_addr_r <= link.raddr;
                end
            end
            if (tick_rden) begin
                rden_r <= link.rden & !shape_bad & !is_shift;
            end
        end
    end

    // FIFO pointers wrap at the word count of their own shape
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (is_fifo && wr_strobe_r) begin
                wr_ptr_r <= (wr_ptr_r + 9'h001) & depth_mask(link.wr_shape);
            end
            if (is_fifo && tick_rden && link.rden && !shape_bad) begin
                rd_ptr_r <= (rd_ptr_r + 9'h001) & depth_mask(link.rd_shape);
            end
        end
    end

    // Shift slot pointer steps on each write strobe, wrapping at the tap length
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sh_ptr_r <= '0;
        end else if (!is_shift || link.in_clr) begin
            sh_ptr_r <= '0;
        end else if (wr_strobe_r) begin
            if (sh_ptr_r + 10'h001 >= link.tap_len) begin
                sh_ptr_r <= '0;
            end else begin
                sh_ptr_r <= sh_ptr_r + 10'h001;
            end
        end
    end

    // Address and data actually applied to the array in each mode
    always_comb begin
        eff_waddr = wr_addr_r;
        eff_raddr = rd_addr_r;
        rd_view = link.rd_shape;
        eff_wdata = wr_data_r;
        if (is_fifo) begin
            eff_waddr = wr_ptr_r;
        end else if (is_shift) begin
            eff_waddr = sh_ptr_r[ADDR_W-1:0];
            eff_raddr = sh_ptr_r[ADDR_W-1:0];
            rd_view = link.wr_shape;
            eff_wdata = shifted;
        end
    end

    // New shift word: older taps move up by one tap width, input enters
    assign shifted = ((rd_data << link.tap_width) | wr_data_r) &
                     ((18'h00001 << width_of(link.wr_shape)) - 18'h00001);

    // Row mask and bits for the write shape
    always_comb begin
        int off;
        int wid;
        off = 0;
        wid = 0;
        wmask = '0;
        wbits = '0;
        w_lin = lin_of(eff_waddr, link.wr_shape);
        off = int'(w_lin[COL_W-1:0]);
        wid = int'(width_of(link.wr_shape));
        if (link.wr_shape == SHAPE_X18) begin
            wmask = '1;
            wbits = eff_wdata;
        end else if (link.wr_shape == SHAPE_X9) begin
            for (int i = 0; i < LANE_W; i++) begin
                wmask[off*LANE_W+i] = 1'b1;
                wbits[off*LANE_W+i] = eff_wdata[i];
            end
        end else begin
            for (int d = 0; d < DATA_W; d++) begin
                if (d >= off && d < off + wid) begin
                    wmask[bit_pos(d)] = 1'b1;
                    wbits[bit_pos(d)] = eff_wdata[d-off];
                end
            end
        end
    end

    // Pick the read word out of its row for the read shape
    always_comb begin
        int off;
        int wid;
        off = 0;
        wid = 0;
        rd_data = '0;
        r_lin = lin_of(eff_raddr, rd_view);
        off = int'(r_lin[COL_W-1:0]);
        wid = int'(width_of(rd_view));
        if (rd_view == SHAPE_X18) begin
            rd_data = row_word;
        end else if (rd_view == SHAPE_X9) begin
            for (int i = 0; i < LANE_W; i++) begin
                rd_data[i] = row_word[off*LANE_W+i];
            end
        end else begin
            for (int i = 0; i < DATA_W; i++) begin
                if (i < wid && i + off < DATA_W) begin
                    rd_data[i] = row_word[bit_pos(i+off)];
                end
            end
        end
    end

    // 576-bit array; a read in the strobe cycle still sees the old row
    sdpram_cells #(
        .INIT_IMAGE(INIT_IMAGE)
    ) u_cells (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .wr_en_in(wr_strobe_r),
        .wr_row_in(w_lin[ADDR_W-1:COL_W]),
        .wr_mask_in(wmask),
        .wr_bits_in(wbits),
        .rd_row_in(r_lin[ADDR_W-1:COL_W]),
        .rd_word_out(row_word)
    );

    // Output register: read words, or all taps at each shift step
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q_r <= '0;
            q_valid_r <= 1'b0;
        end else if (link.out_clr) begin
            q_r <= '0;
            q_valid_r <= 1'b0;
        end else if (is_shift) begin
            q_valid_r <= wr_strobe_r;
            if (wr_strobe_r) begin
                q_r <= rd_data;
            end
        end else begin
            q_valid_r <= tick_out & rden_r;
            if (tick_out && rden_r) begin
                if (wr_strobe_r && !link.rdw_old &&
                    w_lin[ADDR_W-1:COL_W] == r_lin[ADDR_W-1:COL_W]) begin
                    q_r <= UNKNOWN_FILL;
                end else begin
                    q_r <= rd_data;
                end
            end
        end
    end

    // Shape check result for the fabric
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shape_err_r <= 1'b0;
        end else begin
            shape_err_r <= shape_bad;
        end
    end

    // Bypass outside shift mode shows the array word straight away (flow-through)
    assign link.q = (link.out_bypass && !is_shift) ? rd_data : q_r;
    assign link.q_valid = q_valid_r;
    assign shape_err_out = shape_err_r;
endmodule

//--- design/sdpram_fabric.sv
// Fabric-side driver of the memory block: makes the two block clock ticks,
// registers configuration, and holds each request until its tick takes it.
// Assumes user commands arrive on the same clock as one-cycle pulses.
`timescale 1ns/1ps
module sdpram_fabric import sdpram_pkg::*; #(
    parameter int TICK_A_DIV = 1,
    parameter int TICK_B_DIV = 2
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    sdpram_link_if.fabric link,
    input wire mode_type user_mode_in,
    input wire shape_type user_wr_shape_in,
    input wire shape_type user_rd_shape_in,
    input wire logic [3:0] user_clk_sel_in,
    input wire logic user_in_clk_en_in,
    input wire logic user_out_clk_en_in,
    input wire logic user_in_clr_in,
    input wire logic user_out_clr_in,
    input wire logic user_bypass_in,
    input wire logic user_rdw_old_in,
    input wire logic [TAPW_W-1:0] user_tap_width_in,
    input wire logic [LEN_W-1:0] user_tap_len_in,
    input wire logic user_wr_in,
    input wire logic [ADDR_W-1:0] user_waddr_in,
    input wire logic [PORT_W-1:0] user_wdata_in,
    input wire logic user_rd_in,
    input wire logic [ADDR_W-1:0] user_raddr_in,
    output logic [PORT_W-1:0] user_rd_data_out,
    output logic user_rd_valid_out,
    output logic user_busy_out
);
    localparam int DIV_W = 8;
    if (TICK_A_DIV < 1 || TICK_A_DIV > 255 ||
        TICK_B_DIV < 1 || TICK_B_DIV > 255) begin : g_bad_div
        $error("Tick dividers must lie in 1..255");
    end

    logic [DIV_W-1:0] div_a_r, div_b_r;
    logic tick_a_r, tick_b_r, wren_r, rden_r, valid_r;
    logic [PORT_W-1:0] rd_data_r;
    logic wr_taken, rd_taken;

    // Two block clocks as tick trains divided from the system clock
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_a_r <= '0;
            div_b_r <= '0;
            tick_a_r <= 1'b0;
            tick_b_r <= 1'b0;
        end else begin
            tick_a_r <= (div_a_r == DIV_W'(TICK_A_DIV - 1));
            tick_b_r <= (div_b_r == DIV_W'(TICK_B_DIV - 1));
            div_a_r <= (div_a_r == DIV_W'(TICK_A_DIV - 1)) ? '0
                       : div_a_r + 8'h01;
            div_b_r <= (div_b_r == DIV_W'(TICK_B_DIV - 1)) ? '0
                       : div_b_r + 8'h01;
        end
    end

    // A request is taken by the block on its selected tick
    assign wr_taken = wren_r & link.in_clk_en &
                      (link.wr_clk_sel ? tick_b_r : tick_a_r);
    assign rd_taken = rden_r & link.out_clk_en &
                      (link.rden_clk_sel ? tick_b_r : tick_a_r);

    // Configuration and data registered toward the block
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            link.mode <= MODE_SDP;
            link.wr_shape <= SHAPE_X1;
            link.rd_shape <= SHAPE_X1;
            {link.out_clk_sel, link.rden_clk_sel} <= 2'h0;
            {link.rd_addr_clk_sel, link.wr_clk_sel} <= 2'h0;
            link.in_clk_en <= 1'b0;
            link.out_clk_en <= 1'b0;
            link.in_clr <= 1'b0;
            link.out_clr <= 1'b0;
            link.out_bypass <= 1'b0;
            link.rdw_old <= 1'b0;
            link.tap_width <= '0;
            link.tap_len <= '0;
            link.waddr <= '0;
            link.wdata <= '0;
            link.raddr <= '0;
        end else begin
            link.mode <= user_mode_in;
            link.wr_shape <= user_wr_shape_in;
            link.rd_shape <= user_rd_shape_in;
            {link.out_clk_sel, link.rden_clk_sel} <= user_clk_sel_in[3:2];
            {link.rd_addr_clk_sel, link.wr_clk_sel} <= user_clk_sel_in[1:0];
            link.in_clk_en <= user_in_clk_en_in;
            link.out_clk_en <= user_out_clk_en_in;
            link.in_clr <= user_in_clr_in;
            link.out_clr <= user_out_clr_in;
            link.out_bypass <= user_bypass_in;
            link.rdw_old <= user_rdw_old_in;
            link.tap_width <= user_tap_width_in;
            link.tap_len <= user_tap_len_in;
            if (user_wr_in) begin
                link.waddr <= user_waddr_in;
                link.wdata <= user_wdata_in;
            end
            if (user_rd_in) begin
                link.raddr <= user_raddr_in;
            end
        end
    end

    // Enables stand until the block's tick has taken them
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wren_r <= 1'b0;
            rden_r <= 1'b0;
        end else begin
            if (user_wr_in) begin
                wren_r <= 1'b1;
            end else if (wr_taken) begin
                wren_r <= 1'b0;
            end
            if (user_rd_in) begin
                rden_r <= 1'b1;
            end else if (rd_taken) begin
                rden_r <= 1'b0;
            end
        end
    end

    // Catch returned words for the user
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_data_r <= '0;
            valid_r <= 1'b0;
        end else begin
            valid_r <= link.q_valid;
            if (link.q_valid) begin
                rd_data_r <= link.q;
            end
        end
    end

    assign link.tick_a = tick_a_r;
    assign link.tick_b = tick_b_r;
    assign link.wren = wren_r;
    assign link.rden = rden_r;
    assign user_rd_data_out = rd_data_r;
    assign user_rd_valid_out = valid_r;
    assign user_busy_out = wren_r | rden_r;
endmodule

//--- test/sdpram_checker.sv
// Concurrent checks on the link between fabric logic and memory block.
// Assumes both ends run on clk_in and the bench selects tick A everywhere.
`timescale 1ns/1ps
module sdpram_checker import sdpram_pkg::*; (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic tick_a,
    input wire logic tick_b,
    input wire logic in_clk_en,
    input wire logic out_clr,
    input wire logic out_bypass,
    input wire logic wren,
    input wire logic rden,
    input wire mode_type mode,
    input wire logic [PORT_W-1:0] q,
    input wire logic q_valid
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // Tick trains and request handshakes
    a_tick_a_run: assert property (tick_a |=> tick_a)
        else $error("tick a stopped");
    a_tick_b_alt: assert property (tick_b |=> !tick_b ##1 tick_b)
        else $error("tick b not every second cycle");
    a_wren_taken: assert property (wren && tick_a && in_clk_en
        |=> !wren)
        else $error("write request held after its tick");
    a_rden_taken: assert property (rden && tick_a |=> !rden)
        else $error("read request held after its tick");
    // Output register behaviour
    a_valid_cause: assert property ($rose(q_valid)
        && mode != MODE_SHIFT |-> $past(rden, 2))
        else $error("read data without a registered read");
    a_shift_step: assert property ($rose(q_valid)
        && mode == MODE_SHIFT |-> $past(wren, 2))
        else $error("shift taps without a step");
    a_valid_pulse: assert property (q_valid |=> !q_valid)
        else $error("read valid longer than one cycle");
    a_q_hold: assert property (!q_valid && !out_bypass
        && $stable(out_bypass) && !$past(out_clr) |-> $stable(q))
        else $error("output changed without a read");
    a_clr_q: assert property (out_clr && !out_bypass |=> q == '0)
        else $error("output not cleared");
    c_read: cover property ($rose(q_valid));
    c_clear: cover property (out_clr);
    c_write: cover property ($fell(wren));
endmodule

//--- test/tb_top.sv
// Bench: fabric end and memory block joined by the link, user side driven.
// Assumes one 50 MHz clock; all block registers use tick A.
`timescale 1ns/1ps
module tb_top;
    import sdpram_pkg::*;
    logic clk_in = 1'b0, resetn_in = 1'b0, clr = 1'b0, wr = 1'b0, rd = 1'b0;
    mode_type md = MODE_SDP;
    shape_type ws = SHAPE_X18, rs = SHAPE_X18;
    logic [ADDR_W-1:0] wa = '0, ra = '0;
    logic [PORT_W-1:0] wd = '0, rdat;
    logic rv, busy, serr;
    logic byp = 1'b0, rdw = 1'b1;
    int bad_count = 0, tests_run = 0, cyc = 0;
    sdpram_link_if link();
    sdpram_fabric u_sdpram_fabric (.clk_in(clk_in), .resetn_in(resetn_in),
        .link(link), .user_mode_in(md), .user_wr_shape_in(ws),
        .user_rd_shape_in(rs), .user_clk_sel_in(4'h0),
        .user_in_clk_en_in(1'b1), .user_out_clk_en_in(1'b1),
        .user_in_clr_in(clr), .user_out_clr_in(clr), .user_bypass_in(byp),
        .user_rdw_old_in(rdw), .user_tap_width_in(5'h04),
        .user_tap_len_in(10'h002), .user_wr_in(wr), .user_waddr_in(wa),
        .user_wdata_in(wd), .user_rd_in(rd), .user_raddr_in(ra),
        .user_rd_data_out(rdat), .user_rd_valid_out(rv),
        .user_busy_out(busy));
    sdpram_block #(.INIT_IMAGE(576'h3C0F << 90)) u_sdpram_block (
        .clk_in(clk_in), .resetn_in(resetn_in), .link(link),
        .shape_err_out(serr));
    sdpram_checker u_sdpram_checker (.clk_in(clk_in), .resetn_in(resetn_in),
        .tick_a(link.tick_a), .tick_b(link.tick_b),
        .in_clk_en(link.in_clk_en), .out_clr(link.out_clr),
        .out_bypass(link.out_bypass), .wren(link.wren), .rden(link.rden),
        .q(link.q), .q_valid(link.q_valid), .mode(link.mode));
    // Clock and hang limit
    initial forever #10 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            results();
        end
    end
    task automatic chk(input logic [PORT_W-1:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cfg(input mode_type m, input shape_type w, r);
        @(posedge clk_in);
        md <= m;
        ws <= w;
        rs <= r;
        repeat (3) @(posedge clk_in);
    endtask
    // One write, then wait until the fabric has handed it over
    task automatic wr_op(input logic [ADDR_W-1:0] a, logic [PORT_W-1:0] d);
        @(posedge clk_in);
        wr <= 1'b1;
        wa <= a;
        wd <= d;
        @(posedge clk_in);
        wr <= 1'b0;
        repeat (2) @(posedge clk_in);
        for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk_in);
    endtask
    task automatic rd_op(input logic [ADDR_W-1:0] a, logic [PORT_W-1:0] e);
        @(posedge clk_in);
        rd <= 1'b1;
        ra <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        for (int i = 0; i < 20 && rv !== 1'b1; i++) @(posedge clk_in);
        chk(rdat, e);
    endtask
    // Shift: width 4, length 2, taps seen as the old word each step
    task automatic t_shift();
        logic [PORT_W-1:0] exp_q[4] = '{18'h0, 18'h0, 18'h1, 18'h2};
        cfg(MODE_SHIFT, SHAPE_X16, SHAPE_X16);
        for (int i = 0; i < 4; i++) begin
            wr_op('0, PORT_W'(i + 1));
            repeat (4) @(posedge clk_in);
            chk(link.q, exp_q[i]);
        end
    endtask
    // Full rows with parity, preload and boundary row
    task automatic t_parity();
        cfg(MODE_SDP, SHAPE_X18, SHAPE_X18);
        rd_op(9'h005, 18'h03C0F);
        wr_op(9'h003, 18'h2A5A5);
        rd_op(9'h003, 18'h2A5A5);
        wr_op(9'h01F, 18'h1FFFF);
        rd_op(9'h01F, 18'h1FFFF);
    endtask
    // Bytes written narrow, read back wide and as single bits
    task automatic t_mixed();
        cfg(MODE_SDP, SHAPE_X8, SHAPE_X16);
        wr_op(9'h008, 18'h00012);
        wr_op(9'h009, 18'h00034);
        rd_op(9'h004, 18'h03412);
        cfg(MODE_SDP, SHAPE_X8, SHAPE_X1);
        rd_op(9'h041, 18'h00001);
    endtask
    // Read-only mode ignores writes; clears empty the output
    task automatic t_rom();
        cfg(MODE_ROM, SHAPE_X18, SHAPE_X18);
        wr_op(9'h003, 18'h00000);
        rd_op(9'h003, 18'h2A5A5);
        @(posedge clk_in);
        clr <= 1'b1;
        repeat (3) @(posedge clk_in);
        clr <= 1'b0;
        chk(link.q, 18'h0);
    endtask
    // Parity shapes must match on both ports
    task automatic t_shape();
        cfg(MODE_SDP, SHAPE_X9, SHAPE_X18);
        chk({17'h0, serr}, 18'h1);
        cfg(MODE_SDP, SHAPE_X9, SHAPE_X9);
        chk({17'h0, serr}, 18'h0);
        rd_op(9'h006, 18'h001A5);
    endtask
    // Same-row read during write, then a flow-through read
    task automatic t_rdw();
        cfg(MODE_SDP, SHAPE_X18, SHAPE_X18);
        rdw <= 1'b0;
        wr <= 1'b1;
        rd <= 1'b1;
        wa <= 9'h003;
        ra <= 9'h003;
        wd <= 18'h15A5A;
        @(posedge clk_in);
        wr <= 1'b0;
        rd <= 1'b0;
        for (int i = 0; i < 20 && rv !== 1'b1; i++) @(posedge clk_in);
        chk(rdat, UNKNOWN_FILL);
        byp <= 1'b1;
        rd <= 1'b1;
        ra <= 9'h005;
        @(posedge clk_in);
        rd <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk(link.q, 18'h03C0F);
        byp <= 1'b0;
        for (int i = 0; i < 20 && rv !== 1'b1; i++) @(posedge clk_in);
        chk(rdat, 18'h03C0F);
    endtask
    // FIFO ignores addresses; single port reads at the write address
    task automatic t_ports();
        cfg(MODE_FIFO, SHAPE_X18, SHAPE_X18);
        wr_op(9'h00A, 18'h00111);
        wr_op(9'h00A, 18'h00222);
        rd_op(9'h00A, 18'h00111);
        rd_op(9'h00A, 18'h00222);
        cfg(MODE_SINGLE, SHAPE_X18, SHAPE_X18);
        wr_op(9'h007, 18'h0ABCD);
        rd_op(9'h000, 18'h0ABCD);
    endtask
    task automatic results();
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_shift();
        t_parity();
        t_mixed();
        t_rom();
        t_shape();
        t_rdw();
        t_ports();
        results();
    end
endmodule
